// ===== src/ext_alu_top.sv
// Extended-instruction datapath with data memory and Wishbone register access
// Operation
// [RQ1] Any data memory byte reachable directly
// [RQ2] Add with carry, five arithmetic flags
// [RQ3] Add without carry, same flag set
// [RQ4] AND to acc or memory, zero only
// [RQ5] OR to acc or memory, zero only
// [RQ6] Clear byte to zero, flags kept
// [RQ7] Clear selected bit only, flags kept
// [RQ8] Invert byte, zero flag, two destinations
// [RQ9] Decimal adjust acc into memory, carry only
// [RQ10] Decrement byte, zero flag only
// [RQ11] Increment byte, zero flag only
// [RQ12] Load memory into acc, flags kept
// [RQ13] Store acc into memory, flags kept
// [RQ14] Rotate left, bit7 into bit0, no flags
// [RQ15] Rotate left through carry, carry only
// [RQ16] Zero on zero result, carry from bit7
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module ext_alu_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Core state
   output logic [7:0] acc_o,
   output ext_alu_pkg::flags_t flags_o,
   output logic done_o
);
   import ext_alu_pkg::*;

   // Address must fit the command word above its address field
   if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_addr_w
      $error("ADDR_W must be 1 to 16");
   end

   // ==========================================================
   // State
   typedef enum {S_IDLE, S_EXEC, S_DONE} state_t;
   state_t state_q;
   logic [7:0] mem_q [2**ADDR_W];
   logic [7:0] acc_q;
   flags_t flags_q;
   op_t op_q;
   logic [2:0] bit_q;
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] mem_rd_q;
   logic ack_q;
   logic [31:0] dat_q;
   logic done_q;
   alu_res_t res_w;

   // ==========================================================
   // Bus decode
   wire req_w = cyc_i && stb_i && !ack_q;
   wire wr_w = req_w && we_i;
   wire hit_cmd_w = (adr_i == REG_CMD_OFS);
   wire hit_acc_w = (adr_i == REG_ACC_OFS);
   wire hit_flg_w = (adr_i == REG_FLAGS_OFS);
   wire hit_sta_w = (adr_i == REG_STAT_OFS);
   wire busy_w = (state_q != S_IDLE);
   wire cmd_go_w = wr_w && hit_cmd_w && sel_i[0] && !busy_w;
   wire [ADDR_W-1:0] cmd_addr_w = dat_i[CMD_ADDR_LSB +: ADDR_W];
   wire [31:0] rd_w;
   assign rd_w = hit_cmd_w ? {16'h0000, 5'h00, bit_q, 3'h0, op_q} :
                 hit_acc_w ? {24'h000000, acc_q} :
                 hit_flg_w ? {27'h0000000, flags_q} :
                 hit_sta_w ? {31'h00000000, busy_w} :
                 32'h00000000;

   ext_alu_core u_core (
      .op_i(op_q),
      .bit_sel_i(bit_q),
      .acc_i(acc_q),
      .mem_i(mem_rd_q),
      .flags_i(flags_q),
      .res_o(res_w)
   );

   // ==========================================================
   // Bus answer, one cycle after request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= req_w;
         dat_q <= rd_w;
      end
   end

   // ==========================================================
   // Sequencer: fetch operand, execute, write back
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= S_IDLE;
         op_q <= OP_NOP;
         bit_q <= 3'h0;
         addr_q <= '0;
         mem_rd_q <= 8'h00;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (cmd_go_w) begin
                  op_q <= op_t'(dat_i[CMD_OP_LSB +: 5]);
                  bit_q <= dat_i[CMD_BIT_LSB +: 3];
                  addr_q <= cmd_addr_w; // RQ1
                  state_q <= S_EXEC;
               end
            end
            S_EXEC: begin
               mem_rd_q <= mem_q[addr_q]; // RQ1
               state_q <= S_DONE;
            end
            default: begin
               done_q <= 1'b1;
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   wire commit_w = (state_q == S_DONE);

   // ==========================================================
   // Architectural state update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= ACC_RESET;
         flags_q <= FLAGS_RESET;
      end else if (commit_w) begin
         if (res_w.to_acc) begin
            acc_q <= res_w.value;
         end
         flags_q <= res_w.flags; // RQ16
      end else if (wr_w && hit_acc_w && sel_i[0] && !busy_w) begin
         acc_q <= dat_i[7:0];
      end else if (wr_w && hit_flg_w && sel_i[0] && !busy_w) begin
         flags_q <= flags_t'(dat_i[4:0]);
      end
   end

   always_ff @(posedge clk_i) begin
      if (commit_w && res_w.to_mem) begin
         mem_q[addr_q] <= res_w.value; // RQ1
      end
   end

   // ==========================================================
   // Outputs
   assign dat_o = dat_q;
   assign ack_o = ack_q;
   assign acc_o = acc_q;
   assign flags_o = flags_q;
   assign done_o = done_q;

   // ==========================================================
   // Checks
   AST_ADD_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
      commit_w && op_q == OP_ADD_ACC |=> acc_q == 8'h00 |-> flags_q.zero_flag)
      else $error("zero flag wrong after add");
   AST_ADC_SUM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2
      commit_w && op_q == OP_ADC_ACC |=>
      acc_q == 8'($past(acc_q) + $past(mem_rd_q) + {7'h00, $past(flags_q.carry_flag)}))
      else $error("add with carry result wrong");
   AST_ADD_CARRY: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
      commit_w && op_q == OP_ADD_ACC |=>
      flags_q.carry_flag == (({1'b0, $past(acc_q)} + {1'b0, $past(mem_rd_q)}) > 9'h0FF))
      else $error("add carry wrong");
   AST_AND_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
      commit_w && op_q == OP_AND_MEM |=> acc_q == $past(acc_q) &&
      flags_q.carry_flag == $past(flags_q.carry_flag))
      else $error("and to memory touched acc or carry");
   AST_OR_ACC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
      commit_w && op_q == OP_OR_ACC |=> acc_q == ($past(acc_q) | $past(mem_rd_q)))
      else $error("or result wrong");
   AST_CLR_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
      commit_w && (op_q == OP_CLR || op_q == OP_CLR_BIT) |=> $stable(flags_q))
      else $error("clear changed flags");
   AST_CLR_BIT: assert property (@(posedge clk_i) disable iff (rst_i) // RQ7
      commit_w && op_q == OP_CLR_BIT |-> res_w.value[bit_q] == 1'b0 &&
      (res_w.value | (8'h01 << bit_q)) == (mem_rd_q | (8'h01 << bit_q)))
      else $error("bit clear wrong");
   AST_CPL_ACC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
      commit_w && op_q == OP_CPL_ACC |=> acc_q == ~$past(mem_rd_q))
      else $error("invert to acc wrong");
   AST_DAA_MEM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
      commit_w && op_q == OP_DAA |-> !res_w.to_acc && res_w.to_mem &&
      res_w.flags.zero_flag == flags_q.zero_flag)
      else $error("decimal adjust destination or flags wrong");
   AST_DEC_ACC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
      commit_w && op_q == OP_DEC_ACC |=> acc_q == 8'($past(mem_rd_q) - 8'h01))
      else $error("decrement to acc wrong");
   AST_INC_ACC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
      commit_w && op_q == OP_INC_ACC |=> acc_q == 8'($past(mem_rd_q) + 8'h01))
      else $error("increment to acc wrong");
   AST_MOV_ACC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12
      commit_w && op_q == OP_MOV_TO_ACC |=> acc_q == $past(mem_rd_q) && $stable(flags_q))
      else $error("load move wrong");
   AST_MOV_MEM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
      commit_w && op_q == OP_MOV_TO_MEM |-> res_w.value == acc_q && res_w.to_mem)
      else $error("store move wrong");
   AST_RL_ACC: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
      commit_w && op_q == OP_RL_ACC |=> acc_q == {$past(mem_rd_q[6:0]), $past(mem_rd_q[7])})
      else $error("rotate left wrong");
   AST_RLC_C: assert property (@(posedge clk_i) disable iff (rst_i) // RQ15
      commit_w && op_q == OP_RLC_ACC |=> flags_q.carry_flag == $past(mem_rd_q[7]) &&
      acc_q[0] == $past(flags_q.carry_flag))
      else $error("rotate through carry wrong");
   AST_CMD_SPAN: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
      cmd_go_w |=> state_q == S_EXEC ##1 state_q == S_DONE ##1 done_q)
      else $error("command sequence timing wrong");
   AST_ADD_MEM_KEEP: assert property (@(posedge clk_i) disable iff (rst_i) // RQ2 RQ3
      commit_w && (op_q == OP_ADD_MEM || op_q == OP_ADC_MEM) |=> acc_q == $past(acc_q))
      else $error("add to memory touched acc");
   AST_AND_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
      commit_w && op_q == OP_AND_ACC |=> flags_q.zero_flag == (acc_q == 8'h00) &&
      $stable(flags_q.carry_flag))
      else $error("and zero flag wrong");
   AST_CLR_MEM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
      commit_w && op_q == OP_CLR |-> res_w.to_mem && !res_w.to_acc && res_w.value == 8'h00)
      else $error("clear byte wrong");
   AST_CPL_MEM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
      commit_w && op_q == OP_CPL_MEM |=> acc_q == $past(acc_q) &&
      flags_q.zero_flag == ($past(mem_rd_q) == 8'hFF))
      else $error("invert to memory wrong");
   AST_INC_MEM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
      commit_w && op_q == OP_INC_MEM |-> res_w.to_mem && !res_w.to_acc &&
      res_w.value == 8'(mem_rd_q + 8'h01))
      else $error("increment to memory wrong");
   AST_DEC_MEM: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
      commit_w && op_q == OP_DEC_MEM |=> acc_q == $past(acc_q) &&
      flags_q.zero_flag == ($past(mem_rd_q) == 8'h01))
      else $error("decrement to memory wrong");
   AST_RL_FLAGS: assert property (@(posedge clk_i) disable iff (rst_i) // RQ14
      commit_w && (op_q == OP_RL_MEM || op_q == OP_RL_ACC) |=> $stable(flags_q))
      else $error("rotate left changed flags");
   AST_C_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9 RQ15
      commit_w && op_q inside {OP_DAA, OP_RLC_MEM, OP_RLC_ACC} |=>
      $stable(flags_q.zero_flag) && $stable(flags_q.half_carry_flag) &&
      $stable(flags_q.signed_range_exceeded_flag) && $stable(flags_q.signed_compare_flag))
      else $error("flag other than carry changed");
endmodule

// ===== src/ext_alu_pkg.sv
// Package: opcodes, flag layout, register map and reset values for the extended ALU
package ext_alu_pkg;
   // ==========================================================
   // Operations
   typedef enum logic [4:0] {
      OP_ADC_ACC, OP_ADC_MEM, OP_ADD_ACC, OP_ADD_MEM,
      OP_AND_ACC, OP_AND_MEM, OP_OR_ACC, OP_OR_MEM,
      OP_CLR, OP_CLR_BIT, OP_CPL_MEM, OP_CPL_ACC,
      OP_DAA, OP_DEC_MEM, OP_DEC_ACC, OP_INC_MEM, OP_INC_ACC,
      OP_MOV_TO_ACC, OP_MOV_TO_MEM, OP_RL_MEM, OP_RL_ACC,
      OP_RLC_MEM, OP_RLC_ACC, OP_NOP
   } op_t;

   // ==========================================================
   // Status flags
   typedef struct packed {
      logic signed_range_exceeded_flag;
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
      logic signed_compare_flag;
   } flags_t;

   // ==========================================================
   // Result of one operation
   typedef struct packed {
      logic [7:0] value;
      logic to_acc;
      logic to_mem;
      flags_t flags;
   } alu_res_t;

   // ==========================================================
   // Register map (byte offsets on the bus, one 32-bit register every 4)
   localparam logic [3:0] REG_CMD_OFS = 4'h0;
   localparam logic [3:0] REG_ACC_OFS = 4'h4;
   localparam logic [3:0] REG_FLAGS_OFS = 4'h8;
   localparam logic [3:0] REG_STAT_OFS = 4'hC;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_BIT_LSB = 8;
   localparam int CMD_ADDR_LSB = 16;
   localparam int STAT_BUSY_BIT = 0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam flags_t FLAGS_RESET = '0;
   localparam logic [3:0] BCD_LIMIT = 4'h9;
   localparam logic [7:0] BCD_ADJ_LO = 8'h06;
   localparam logic [7:0] BCD_ADJ_HI = 8'h60;
   localparam logic [7:0] CLEAR_VALUE = 8'h00;
endpackage

// ===== src/ext_alu_core.sv
// Combinational datapath for the extended instruction group
`timescale 1ns/1ps
module ext_alu_core (
   // Operation
   input wire ext_alu_pkg::op_t op_i,
   input wire logic [2:0] bit_sel_i,
   // Operands
   input wire logic [7:0] acc_i,
   input wire logic [7:0] mem_i,
   input wire ext_alu_pkg::flags_t flags_i,
   // Result
   output ext_alu_pkg::alu_res_t res_o
);
   import ext_alu_pkg::*;

   // ==========================================================
   // Adder with flag generation
   function automatic flags_t add_flags(input logic [7:0] a, input logic [7:0] b,
                                        input logic ci, input flags_t f);
      logic [8:0] s;
      logic [4:0] h;
      flags_t r;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      r = f;
      r.carry_flag = s[8];
      r.half_carry_flag = h[4];
      r.zero_flag = (s[7:0] == 8'h00);
      r.signed_range_exceeded_flag = (a[7] == b[7]) && (s[7] != a[7]);
      r.signed_compare_flag = s[7] ^ r.signed_range_exceeded_flag;
      return r;
   endfunction

   wire [7:0] sum_w = acc_i + mem_i + {7'h00, flags_i.carry_flag};
   wire [7:0] sum_nc_w = acc_i + mem_i;
   wire [7:0] and_w = acc_i & mem_i;
   wire [7:0] or_w = acc_i | mem_i;
   wire [7:0] cpl_w = ~mem_i;
   wire [7:0] dec_w = mem_i - 8'h01;
   wire [7:0] inc_w = mem_i + 8'h01;
   wire [7:0] rl_w = {mem_i[6:0], mem_i[7]};
   wire [7:0] rlc_w = {mem_i[6:0], flags_i.carry_flag};
   wire [7:0] clr_bit_w = mem_i & ~(8'h01 << bit_sel_i);
   wire adj_lo_w = (acc_i[3:0] > BCD_LIMIT) || flags_i.half_carry_flag;
   wire adj_hi_w = (acc_i[7:4] > BCD_LIMIT) || flags_i.carry_flag;
   wire [8:0] daa_w = {1'b0, acc_i} + {1'b0, (adj_lo_w ? BCD_ADJ_LO : 8'h00)}
                      + {1'b0, (adj_hi_w ? BCD_ADJ_HI : 8'h00)};

   function automatic flags_t z_only(input logic [7:0] v, input flags_t f);
      flags_t r;
      r = f;
      r.zero_flag = (v == 8'h00);
      return r;
   endfunction

   // ==========================================================
   // Operation select
   always_comb begin
      res_o = '{value: 8'h00, to_acc: 1'b0, to_mem: 1'b0, flags: flags_i};
      case (op_i)
         OP_ADC_ACC, OP_ADC_MEM: begin
            res_o.value = sum_w; // RQ2
            res_o.flags = add_flags(acc_i, mem_i, flags_i.carry_flag, flags_i); // RQ2 RQ16
            res_o.to_acc = (op_i == OP_ADC_ACC);
            res_o.to_mem = (op_i == OP_ADC_MEM);
         end
         OP_ADD_ACC, OP_ADD_MEM: begin
            res_o.value = sum_nc_w; // RQ3
            res_o.flags = add_flags(acc_i, mem_i, 1'b0, flags_i); // RQ3 RQ16
            res_o.to_acc = (op_i == OP_ADD_ACC);
            res_o.to_mem = (op_i == OP_ADD_MEM);
         end
         OP_AND_ACC, OP_AND_MEM: begin
            res_o.value = and_w; // RQ4
            res_o.flags = z_only(and_w, flags_i); // RQ4 RQ16
            res_o.to_acc = (op_i == OP_AND_ACC);
            res_o.to_mem = (op_i == OP_AND_MEM);
         end
         OP_OR_ACC, OP_OR_MEM: begin
            res_o.value = or_w; // RQ5
            res_o.flags = z_only(or_w, flags_i); // RQ5 RQ16
            res_o.to_acc = (op_i == OP_OR_ACC);
            res_o.to_mem = (op_i == OP_OR_MEM);
         end
         OP_CLR: begin
            res_o.value = CLEAR_VALUE; // RQ6
            res_o.to_mem = 1'b1;
         end
         OP_CLR_BIT: begin
            res_o.value = clr_bit_w; // RQ7
            res_o.to_mem = 1'b1;
         end
         OP_CPL_MEM, OP_CPL_ACC: begin
            res_o.value = cpl_w; // RQ8
            res_o.flags = z_only(cpl_w, flags_i); // RQ8
            res_o.to_acc = (op_i == OP_CPL_ACC);
            res_o.to_mem = (op_i == OP_CPL_MEM);
         end
         OP_DAA: begin
            res_o.value = daa_w[7:0]; // RQ9
            res_o.flags.carry_flag = flags_i.carry_flag | daa_w[8]; // RQ9
            res_o.to_mem = 1'b1;
         end
         OP_DEC_MEM, OP_DEC_ACC: begin
            res_o.value = dec_w; // RQ10
            res_o.flags = z_only(dec_w, flags_i); // RQ10
            res_o.to_acc = (op_i == OP_DEC_ACC);
            res_o.to_mem = (op_i == OP_DEC_MEM);
         end
         OP_INC_MEM, OP_INC_ACC: begin
            res_o.value = inc_w; // RQ11
            res_o.flags = z_only(inc_w, flags_i); // RQ11
            res_o.to_acc = (op_i == OP_INC_ACC);
            res_o.to_mem = (op_i == OP_INC_MEM);
         end
         OP_MOV_TO_ACC: begin
            res_o.value = mem_i; // RQ12
            res_o.to_acc = 1'b1;
         end
         OP_MOV_TO_MEM: begin
            res_o.value = acc_i; // RQ13
            res_o.to_mem = 1'b1;
         end
         OP_RL_MEM, OP_RL_ACC: begin
            res_o.value = rl_w; // RQ14
            res_o.to_acc = (op_i == OP_RL_ACC);
            res_o.to_mem = (op_i == OP_RL_MEM);
         end
         OP_RLC_MEM, OP_RLC_ACC: begin
            res_o.value = rlc_w; // RQ15
            res_o.flags.carry_flag = mem_i[7]; // RQ15
            res_o.to_acc = (op_i == OP_RLC_ACC);
            res_o.to_mem = (op_i == OP_RLC_MEM);
         end
         default: begin
            res_o.value = 8'h00;
         end
      endcase
   end
endmodule

// ===== verification/ext_mem_model.sv
// Reference model of the data memory, accumulator and flags behind the extended datapath
`timescale 1ns/1ps
module ext_mem_model;
   import ext_alu_pkg::*;
   // ==========================================================
   // Mirrored state
   logic [7:0] mem [256];
   logic [7:0] acc;
   flags_t f;
   // ==========================================================
   // One operation
   task automatic apply(input op_t op, input logic [2:0] b, input logic [7:0] a);
      logic [7:0] m;
      logic [7:0] r;
      logic [8:0] s;
      logic ci;
      logic ta;
      m = mem[a];
      r = m;
      ta = op inside {OP_ADC_ACC, OP_ADD_ACC, OP_AND_ACC, OP_OR_ACC, OP_CPL_ACC, OP_DEC_ACC,
         OP_INC_ACC, OP_MOV_TO_ACC, OP_RL_ACC, OP_RLC_ACC};
      case (op)
         OP_ADC_ACC, OP_ADC_MEM, OP_ADD_ACC, OP_ADD_MEM: begin
            ci = (op == OP_ADC_ACC || op == OP_ADC_MEM) ? f.carry_flag : 1'b0;
            s = {1'b0, acc} + {1'b0, m} + {8'h00, ci};
            r = s[7:0];
            f.carry_flag = s[8];
            f.half_carry_flag = ({1'b0, acc[3:0]} + {1'b0, m[3:0]} + {4'h0, ci}) > 5'h0F;
            f.signed_range_exceeded_flag = (acc[7] == m[7]) && (r[7] != acc[7]);
            f.signed_compare_flag = r[7] ^ f.signed_range_exceeded_flag;
         end
         OP_AND_ACC, OP_AND_MEM: r = acc & m;
         OP_OR_ACC, OP_OR_MEM: r = acc | m;
         OP_CLR: r = 8'h00;
         OP_CLR_BIT: r[b] = 1'b0;
         OP_CPL_MEM, OP_CPL_ACC: r = ~m;
         OP_DAA: begin
            s = {1'b0, acc};
            if (acc[3:0] > 4'h9 || f.half_carry_flag) s = s + 9'h006;
            if (acc[7:4] > 4'h9 || f.carry_flag) s = s + 9'h060;
            r = s[7:0];
            f.carry_flag = f.carry_flag | s[8];
         end
         OP_DEC_MEM, OP_DEC_ACC: r = m - 8'h01;
         OP_INC_MEM, OP_INC_ACC: r = m + 8'h01;
         OP_MOV_TO_ACC: r = m;
         OP_MOV_TO_MEM: r = acc;
         OP_RL_MEM, OP_RL_ACC: r = {m[6:0], m[7]};
         OP_RLC_MEM, OP_RLC_ACC: begin
            r = {m[6:0], f.carry_flag};
            f.carry_flag = m[7];
         end
         default: r = m;
      endcase
      if (op inside {[OP_ADC_ACC:OP_OR_MEM], OP_CPL_MEM, OP_CPL_ACC, [OP_DEC_MEM:OP_INC_ACC]})
         f.zero_flag = (r == 8'h00);
      if (ta) acc = r;
      else if (op != OP_NOP) mem[a] = r;
   endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the extended datapath over its Wishbone registers
`timescale 1ns/1ps
module tb_top;
   import ext_alu_pkg::*;
   typedef struct {
      logic [7:0] acc;
      logic [4:0] flg;
      op_t op;
      logic [2:0] b;
      logic [7:0] a;
   } step_t;
   // ==========================================================
   // Signals
   logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, done_o;
   logic [3:0] adr_i, sel_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [7:0] acc_o;
   flags_t flags_o;
   int n_errors = 0;
   int n_tests = 0;
   int n_done = 0;
   int n_ops = 0;
   step_t steps[$];
   ext_alu_top #(.ADDR_W(8)) ext_alu_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .acc_o(acc_o), .flags_o(flags_o), .done_o(done_o));
   ext_mem_model ext_mem_model_inst ();
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (done_o === 1'b1) n_done++;
   // ==========================================================
   // Tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
      input logic [31:0] wd, output logic [31:0] q);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= we;
      adr_i <= adr;
      sel_i <= sel;
      dat_i <= wd;
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic run_op(input op_t op, input logic [2:0] b, input logic [7:0] a,
      input logic poke);
      logic [31:0] q;
      int n;
      wb_xfer(1'b1, REG_CMD_OFS, 4'hF, {8'h00, a, 5'h00, b, 3'h0, op}, q);
      ext_mem_model_inst.apply(op, b, a);
      if (poke) begin
         wb_xfer(1'b1, REG_ACC_OFS, 4'hF, 32'h0000_0055, q);
         ext_mem_model_inst.acc = 8'h55;
      end
      q = 32'h0000_0001;
      n = 0;
      while (q[0] !== 1'b0 && n < 100) begin
         wb_xfer(1'b0, REG_STAT_OFS, 4'hF, 32'h0, q);
         n++;
      end
      if (n >= 100) begin
         n_errors++;
         $display("mismatch status busy expected 0 seen 1");
      end
      n_ops++;
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Watchdog
   initial begin
      repeat (30000) @(posedge clk_i);
      n_errors++;
      wrap_up();
   end
   // ==========================================================
   // Tests
   initial begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i} = 3'h0;
      adr_i = 4'h0;
      sel_i = 4'h0;
      dat_i = 32'h0;
      steps = '{'{8'h7F, 5'h00, OP_MOV_TO_MEM, 3'h0, 8'h10},
         '{8'h80, 5'h00, OP_MOV_TO_MEM, 3'h0, 8'hFF},
         '{8'h0F, 5'h1F, OP_MOV_TO_MEM, 3'h0, 8'h00}, '{8'h01, 5'h00, OP_ADD_ACC, 3'h0, 8'h10},
         '{8'h80, 5'h02, OP_ADC_ACC, 3'h0, 8'hFF}, '{8'hF1, 5'h00, OP_ADD_MEM, 3'h0, 8'h00},
         '{8'h00, 5'h02, OP_ADC_MEM, 3'h0, 8'h10}, '{8'h01, 5'h02, OP_ADD_ACC, 3'h0, 8'hFF},
         '{8'hF0, 5'h00, OP_AND_ACC, 3'h0, 8'h00}, '{8'hFF, 5'h08, OP_AND_MEM, 3'h0, 8'hFF},
         '{8'h00, 5'h1F, OP_OR_ACC, 3'h0, 8'h00}, '{8'h01, 5'h08, OP_OR_MEM, 3'h0, 8'h00},
         '{8'h00, 5'h1F, OP_CLR, 3'h0, 8'h10}, '{8'h00, 5'h15, OP_CLR_BIT, 3'h7, 8'hFF},
         '{8'h00, 5'h0A, OP_CLR_BIT, 3'h0, 8'h00}, '{8'h00, 5'h08, OP_CPL_MEM, 3'h0, 8'h10},
         '{8'h33, 5'h00, OP_CPL_ACC, 3'h0, 8'h10}, '{8'h3C, 5'h00, OP_DAA, 3'h0, 8'h00},
         '{8'hA5, 5'h00, OP_DAA, 3'h0, 8'h10}, '{8'h11, 5'h04, OP_DAA, 3'h0, 8'hFF},
         '{8'h22, 5'h1B, OP_DAA, 3'h0, 8'h00}, '{8'h00, 5'h00, OP_DEC_MEM, 3'h0, 8'hFF},
         '{8'h00, 5'h00, OP_DEC_ACC, 3'h0, 8'h10}, '{8'h00, 5'h00, OP_INC_MEM, 3'h0, 8'h00},
         '{8'h00, 5'h00, OP_INC_ACC, 3'h0, 8'h10}, '{8'h00, 5'h1F, OP_MOV_TO_ACC, 3'h0, 8'hFF},
         '{8'h00, 5'h1F, OP_RL_MEM, 3'h0, 8'h10}, '{8'h00, 5'h00, OP_RL_ACC, 3'h0, 8'hFF},
         '{8'h00, 5'h02, OP_RLC_MEM, 3'h0, 8'h10}, '{8'h00, 5'h1D, OP_RLC_ACC, 3'h0, 8'hFF},
         '{8'h5A, 5'h1F, OP_NOP, 3'h0, 8'h10}};
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("acc reset", {24'h0, ACC_RESET}, {24'h0, acc_o});
      chk("flags reset", {27'h0, FLAGS_RESET}, {27'h0, flags_o});
      wb_xfer(1'b1, 4'h2, 4'hF, 32'hFFFF_FFFF, rd);
      wb_xfer(1'b0, 4'h2, 4'hF, 32'h0, rd);
      chk("unmapped read", 32'h0, rd);
      foreach (steps[i]) begin
         wb_xfer(1'b1, REG_ACC_OFS, 4'hF, {24'h0, steps[i].acc}, rd);
         ext_mem_model_inst.acc = steps[i].acc;
         wb_xfer(1'b1, REG_FLAGS_OFS, 4'hF, {27'h0, steps[i].flg}, rd);
         ext_mem_model_inst.f = steps[i].flg;
         run_op(steps[i].op, steps[i].b, steps[i].a, 1'b0);
         chk("acc", {24'h0, ext_mem_model_inst.acc}, {24'h0, acc_o});
         chk("flags", {27'h0, ext_mem_model_inst.f}, {27'h0, flags_o});
         run_op(OP_MOV_TO_ACC, 3'h0, steps[i].a, 1'b0);
         chk("mem", {24'h0, ext_mem_model_inst.acc}, {24'h0, acc_o});
         chk("flags kept", {27'h0, ext_mem_model_inst.f}, {27'h0, flags_o});
      end
      wb_xfer(1'b1, REG_ACC_OFS, 4'hE, 32'h0000_0033, rd);
      chk("acc no sel", {24'h0, ext_mem_model_inst.acc}, {24'h0, acc_o});
      run_op(OP_MOV_TO_ACC, 3'h0, 8'h00, 1'b1);
      chk("acc write after op", {24'h0, ext_mem_model_inst.acc}, {24'h0, acc_o});
      wb_xfer(1'b0, REG_ACC_OFS, 4'hF, 32'h0, rd);
      chk("acc read", {24'h0, ext_mem_model_inst.acc}, rd);
      wb_xfer(1'b0, REG_FLAGS_OFS, 4'hF, 32'h0, rd);
      chk("flags read", {27'h0, ext_mem_model_inst.f}, rd);
      chk("done count", n_ops, n_done);
      wrap_up();
   end
endmodule
